/* hw/dlei_top.sv */
// Latch-edge selection, data clock generation and I/Q interpolation chain
//
// Summary of operation
// - Capture edge comes from offset field, bits 7:4 of register 05h.
// - Offset field is signed: 0..7 forward, codes with top bit set give -8..-1.
// - Offset field resets to zero, the nominal capture edge.
// - Zero offset: capture edge just before data clock rise, or fall if polarity set.
// - Only interpolating modes offer more than one capture edge.
// - Eight-times mode uses all sixteen codes: eight edges before, seven after.
// - Four-times mode: even codes only, offsets +3 down to -4.
// - Two-times mode: offsets limited to +1 down to -2.
// - Offset moves the data clock; capture edge keeps its place relative to it.
// - In 8x mode, code 1111 moves one cycle earlier, code 0001 one cycle later.
// - Select 00/01/10/11 gives factor 1/2/4/8; output rate is input times factor.
// - Cascaded filter stages, one identical chain each for I and Q.
// - Converter clock is factor times data clock, but twice data clock in 1x mode; one capture per factor cycles.
`timescale 1ns/1ps
module dlei_top (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic data_clock_polarity_i,
	input wire logic [1:0] interpolation_select_i,
	input wire logic clk_conv_i,
	input wire dlei_pkg::dlei_sample_t sample_data_i,
	output logic sample_ready_o,
	output logic sample_clock_out_o,
	input wire logic dac_ready_i,
	output logic dac_valid_o,
	output dlei_pkg::dlei_sample_t dac_data_o
);
	localparam int W = dlei_pkg::SAMPLE_W;
	localparam int CH = dlei_pkg::CHANNELS;
	localparam int ST = dlei_pkg::STAGES;

	// ==========================================================
	// Decoding helpers
	function automatic logic signed [3:0] dec_offset(input logic [3:0] code,
			input dlei_pkg::dlei_interpolation_select_t m);
		logic signed [3:0] s;
		s = $signed(code);
		case (m)
			dlei_pkg::INTERPOLATION_SELECT_X8: dec_offset = s;
			dlei_pkg::INTERPOLATION_SELECT_X4: dec_offset = s >>> 1;
			dlei_pkg::INTERPOLATION_SELECT_X2: dec_offset = s >>> 2;
			default: dec_offset = 4'sh0;
		endcase
	endfunction

	function automatic logic [2:0] mask_of(input dlei_pkg::dlei_interpolation_select_t m);
		case (m)
			dlei_pkg::INTERPOLATION_SELECT_X8: mask_of = 3'h7;
			dlei_pkg::INTERPOLATION_SELECT_X4: mask_of = 3'h3;
			dlei_pkg::INTERPOLATION_SELECT_X2: mask_of = 3'h1;
			default: mask_of = 3'h0;
		endcase
	endfunction

	function automatic logic signed [W-1:0] avg2(input logic signed [W-1:0] a,
			input logic signed [W-1:0] b);
		logic signed [W:0] sum;
		sum = {a[W-1], a} + {b[W-1], b};
		avg2 = sum[W:1];
	endfunction

	// ==========================================================
	// Register port, system clock
	logic [7:0] latch_edge_adjust_reg;
	logic hit;

	assign hit = (reg_addr_i == dlei_pkg::LATCH_EDGE_ADDR);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			latch_edge_adjust_reg <= dlei_pkg::LATCH_EDGE_RESET;
			reg_rdata_o <= dlei_pkg::RDATA_IDLE;
		end else begin
			if (reg_wr_i && hit) begin
				latch_edge_adjust_reg <= reg_wdata_i;
			end
			if (reg_rd_i) begin
				reg_rdata_o <= hit ? latch_edge_adjust_reg : dlei_pkg::RDATA_IDLE;
			end
		end
	end

	// ==========================================================
	// Configuration crossing by toggle handshake
	dlei_pkg::dlei_cfg_t cfg_new;
	dlei_pkg::dlei_cfg_t cfg_hold;
	logic req;
	logic ack_s1;
	logic ack_s2;
	logic req_s1;
	logic req_s2;
	logic req_s3;
	logic cfg_load;
	logic cfg_fresh;
	dlei_pkg::dlei_cfg_t act;

	assign cfg_new = '{latch_edge_adjust_reg[dlei_pkg::OFFSET_MSB:dlei_pkg::OFFSET_LSB],
		data_clock_polarity_i, dlei_pkg::dlei_interpolation_select_t'(interpolation_select_i)};

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_hold <= dlei_pkg::CFG_RESET;
			req <= 1'h0;
			ack_s1 <= 1'h0;
			ack_s2 <= 1'h0;
		end else begin
			ack_s1 <= req_s3;
			ack_s2 <= ack_s1;
			if (ack_s2 == req && cfg_new != cfg_hold) begin
				cfg_hold <= cfg_new;
				req <= ~req;
			end
		end
	end

	// ==========================================================
	// Converter clock reset and synchronisers
	logic rst_conv_s1;
	logic rst_conv_n;
	dlei_pkg::dlei_sample_t smp_s1;
	dlei_pkg::dlei_sample_t smp_s2;

	always_ff @(posedge clk_conv_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_conv_s1 <= 1'h0;
			rst_conv_n <= 1'h0;
		end else begin
			rst_conv_s1 <= 1'h1;
			rst_conv_n <= rst_conv_s1;
		end
	end

	assign cfg_load = req_s2 ^ req_s3;

	always_ff @(posedge clk_conv_i or negedge rst_conv_n) begin
		if (!rst_conv_n) begin
			req_s1 <= 1'h0;
			req_s2 <= 1'h0;
			req_s3 <= 1'h0;
			cfg_fresh <= 1'h0;
			act <= dlei_pkg::CFG_RESET;
			smp_s1 <= '0;
			smp_s2 <= '0;
		end else begin
			req_s1 <= req;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
			cfg_fresh <= cfg_load;
			act <= cfg_load ? cfg_hold : act;
			smp_s1 <= sample_data_i;
			smp_s2 <= smp_s1;
		end
	end

	// ==========================================================
	// Phase counter, data clock and capture edge
	logic [2:0] base;
	logic [2:0] mask;
	logic [2:0] half;
	logic [2:0] phase;
	logic [2:0] next_base;
	logic [2:0] next_phase;
	logic [2:0] cap_phase;
	logic signed [3:0] eff;
	logic is_1x;
	logic cap_en;
	logic next_sclk;

	assign mask = mask_of(act.interpolation_select);
	assign is_1x = (mask == 3'h0);
	assign half = 3'((mask >> 1) + 3'h1);
	assign eff = dec_offset(act.latch_edge_offset, act.interpolation_select);
	assign phase = 3'(base - eff[2:0]) & mask;
	assign next_base = 3'(base + 3'h1) & mask;
	assign next_phase = 3'(next_base - eff[2:0]) & mask;
	assign cap_phase = act.data_clock_polarity ? 3'(half - 3'h1) : mask;
	assign cap_en = is_1x || (phase == cap_phase);
	assign next_sclk = is_1x ? ~sample_clock_out_o : (next_phase < half);

	always_ff @(posedge clk_conv_i or negedge rst_conv_n) begin
		if (!rst_conv_n) begin
			base <= 3'h0;
			sample_clock_out_o <= 1'h0;
		end else begin
			base <= next_base;
			sample_clock_out_o <= next_sclk;
		end
	end

	// ==========================================================
	// Capture buffer
	logic buf_in_ready;
	logic buf_out_valid;
	logic pop;
	dlei_pkg::dlei_sample_t buf_out;
	logic [ST:0] stb;

	assign pop = stb[0] && dac_ready_i && buf_out_valid;

	dlei_buf #(
		.WIDTH($bits(dlei_pkg::dlei_sample_t)),
		.DEPTH(dlei_pkg::BUF_DEPTH)
	) u_buf (
		.clk_i(clk_conv_i),
		.rst_n_i(rst_conv_n),
		.in_valid_i(cap_en),
		.in_ready_o(buf_in_ready),
		.in_data_i(smp_s2),
		.out_valid_o(buf_out_valid),
		.out_ready_i(pop),
		.out_data_o(buf_out)
	);

	// ==========================================================
	// Interpolation chain, identical for I and Q
	logic signed [W-1:0] st_in [CH][ST];
	logic signed [W-1:0] st_prev [CH][ST];
	logic signed [W-1:0] st_out [CH][ST];
	logic signed [W-1:0] chan_in [CH];
	logic primed;

	assign chan_in[0] = buf_out.i;
	assign chan_in[1] = buf_out.q;

	genvar gl;
	genvar gc;
	genvar gs;
	generate
		for (gl = 0; gl <= ST; gl++) begin : g_stb
			assign stb[gl] = ((base & (mask >> gl)) == 3'h0);
		end
		for (gc = 0; gc < CH; gc++) begin : g_ch
			for (gs = 0; gs < ST; gs++) begin : g_st
				if (gs == 0) begin : g_first
					assign st_in[gc][gs] = buf_out_valid ? chan_in[gc] : st_prev[gc][gs];
				end else begin : g_next
					assign st_in[gc][gs] = st_out[gc][gs-1];
				end
				always_ff @(posedge clk_conv_i or negedge rst_conv_n) begin
					if (!rst_conv_n) begin
						st_prev[gc][gs] <= '0;
						st_out[gc][gs] <= '0;
					end else if (dac_ready_i) begin
						if (stb[gs]) begin
							st_prev[gc][gs] <= st_in[gc][gs];
							st_out[gc][gs] <= st_prev[gc][gs];
						end else if (stb[gs+1]) begin
							st_out[gc][gs] <= avg2(st_out[gc][gs], st_prev[gc][gs]);
						end
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// Output registers
	always_ff @(posedge clk_conv_i or negedge rst_conv_n) begin
		if (!rst_conv_n) begin
			primed <= 1'h0;
			dac_valid_o <= 1'h0;
			dac_data_o <= '0;
			sample_ready_o <= 1'h0;
		end else begin
			primed <= primed || pop;
			dac_valid_o <= primed;
			sample_ready_o <= buf_in_ready;
			if (dac_ready_i) begin
				dac_data_o <= '{st_out[1][ST-1], st_out[0][ST-1]};
			end
		end
	end

	// ==========================================================
	// Assertions
	property p_offset_write;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(reg_wr_i && hit) |=> (latch_edge_adjust_reg[7:4] == $past(reg_wdata_i[7:4]));
	endproperty
	a_offset_write: assert property (p_offset_write) else $error("offset not stored");

	property p_dec_x8;
		@(posedge clk_conv_i) disable iff (!rst_conv_n)
		(act.interpolation_select == dlei_pkg::INTERPOLATION_SELECT_X8) |-> (eff == $signed(act.latch_edge_offset));
	endproperty
	a_dec_x8: assert property (p_dec_x8) else $error("8x offset decode wrong");

	property p_range_x4;
		@(posedge clk_conv_i) disable iff (!rst_conv_n)
		(act.interpolation_select == dlei_pkg::INTERPOLATION_SELECT_X4) |-> (eff <= 4'sh3 && eff >= -4'sh4);
	endproperty
	a_range_x4: assert property (p_range_x4) else $error("4x offset out of range");

	property p_range_x2;
		@(posedge clk_conv_i) disable iff (!rst_conv_n)
		(act.interpolation_select == dlei_pkg::INTERPOLATION_SELECT_X2) |-> (eff <= 4'sh1 && eff >= -4'sh2);
	endproperty
	a_range_x2: assert property (p_range_x2) else $error("2x offset out of range");

	property p_single_edge;
		@(posedge clk_conv_i) disable iff (!rst_conv_n)
		(act.interpolation_select == dlei_pkg::INTERPOLATION_SELECT_NONE) |-> (cap_en && eff == 4'sh0);
	endproperty
	a_single_edge: assert property (p_single_edge) else $error("1x must capture each edge");

	property p_cap_rise;
		@(posedge clk_conv_i) disable iff (!rst_conv_n || cfg_load || cfg_fresh)
		(cap_en && !is_1x && !act.data_clock_polarity && !cfg_fresh) |=> $rose(sample_clock_out_o);
	endproperty
	a_cap_rise: assert property (p_cap_rise) else $error("capture not before rise");

	property p_cap_fall;
		@(posedge clk_conv_i) disable iff (!rst_conv_n || cfg_load || cfg_fresh)
		(cap_en && !is_1x && act.data_clock_polarity && !cfg_fresh) |=> $fell(sample_clock_out_o);
	endproperty
	a_cap_fall: assert property (p_cap_fall) else $error("capture not before fall");

	property p_cap_period_x8;
		@(posedge clk_conv_i) disable iff (!rst_conv_n || cfg_load || cfg_fresh)
		(cap_en && act.interpolation_select == dlei_pkg::INTERPOLATION_SELECT_X8) |=> (!cap_en)[*7] ##1 cap_en;
	endproperty
	a_cap_period_x8: assert property (p_cap_period_x8) else $error("8x capture period");

	property p_in_rate_x4;
		@(posedge clk_conv_i) disable iff (!rst_conv_n || cfg_load || cfg_fresh)
		(stb[0] && act.interpolation_select == dlei_pkg::INTERPOLATION_SELECT_X4) |=> (!stb[0])[*3] ##1 stb[0];
	endproperty
	a_in_rate_x4: assert property (p_in_rate_x4) else $error("4x input rate wrong");
endmodule

/* hw/dlei_pkg.sv */
// Shared constants and types for the latch-edge and interpolation block
package dlei_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] LATCH_EDGE_ADDR = 8'h05;
	localparam int OFFSET_LSB = 4;
	localparam int OFFSET_MSB = 7;
	localparam logic [7:0] LATCH_EDGE_RESET = 8'h00;
	localparam logic [7:0] RDATA_IDLE = 8'h00;

	// ==========================================================
	// Data path sizes
	localparam int SAMPLE_W = 12;
	localparam int CHANNELS = 2;
	localparam int STAGES = 3;
	localparam int BUF_DEPTH = 2;

	// ==========================================================
	// Modes and carriers
	typedef enum logic [1:0] {
		INTERPOLATION_SELECT_NONE = 2'b00,
		INTERPOLATION_SELECT_X2 = 2'b01,
		INTERPOLATION_SELECT_X4 = 2'b10,
		INTERPOLATION_SELECT_X8 = 2'b11
	} dlei_interpolation_select_t;

	typedef struct packed {
		logic [3:0] latch_edge_offset;
		logic data_clock_polarity;
		dlei_interpolation_select_t interpolation_select;
	} dlei_cfg_t;

	typedef struct packed {
		logic [SAMPLE_W-1:0] q;
		logic [SAMPLE_W-1:0] i;
	} dlei_sample_t;

	localparam dlei_cfg_t CFG_RESET = '{4'h0, 1'h0, INTERPOLATION_SELECT_NONE};

endpackage

/* hw/dlei_buf.sv */
// Small valid/ready buffer between sample capture and the filter chain
`timescale 1ns/1ps
module dlei_buf #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 2
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_params
		$error("dlei_buf: DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic push;
	logic pop;

	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign next_cnt = CNT_W'(cnt + CNT_W'(push) - CNT_W'(pop));
	assign out_data_o = mem[rd_ptr];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			cnt <= '0;
			in_ready_o <= 1'h1;
			out_valid_o <= 1'h0;
		end else begin
			wr_ptr <= push ? PTR_W'(wr_ptr + 1'h1) : wr_ptr;
			rd_ptr <= pop ? PTR_W'(rd_ptr + 1'h1) : rd_ptr;
			cnt <= next_cnt;
			in_ready_o <= (next_cnt != CNT_W'(DEPTH));
			out_valid_o <= (next_cnt != '0);
		end
	end
endmodule

/* testbench/dlei_engine.sv */
// Behavioural engine that feeds I/Q words timed from the data clock
`timescale 1ns/1ps
module dlei_engine (
	input wire logic clk_conv_i,
	input wire logic rst_n_i,
	input wire logic sample_clock_out_i,
	input wire logic data_clock_polarity_i,
	input wire logic [dlei_pkg::SAMPLE_W-1:0] value_i,
	output dlei_pkg::dlei_sample_t sample_data_o
);
	logic last_sco;
	// ==========================================================
	// New word launched after each data clock rise, or fall when polarity is set
	always_ff @(posedge clk_conv_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_sco <= 1'b0;
			sample_data_o <= '0;
		end else begin
			last_sco <= sample_clock_out_i;
			if (sample_clock_out_i != last_sco && sample_clock_out_i != data_clock_polarity_i) begin
				sample_data_o <= {value_i, value_i};
			end
		end
	end
endmodule

/* testbench/dlei_top_test.sv */
// Self-checking bench for latch-edge selection and interpolation
`timescale 1ns/1ps
module dlei_top_test;
	logic clk_sys_i = 0;
	logic clk_conv_i = 0;
	logic rst_n_i;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic pol = 0;
	logic dac_ready = 1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [1:0] sel = 2'b00;
	logic [11:0] eng_val = 12'h000;
	logic sample_ready, sco, dac_valid;
	logic sco_q = 0;
	dlei_pkg::dlei_sample_t sample_data, dac_data;
	logic [15:0] lfsr = 16'hC84E;
	int fails = 0;
	int n_tests = 0;
	int cc = 0;
	int rise_a = 0;
	int rise_b = 0;
	int fall_a = 0;

	// ==========================================================
	// Clocks, edge tracker and instances
	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		#3;
		forever #62.5 clk_conv_i = ~clk_conv_i;
	end
	always @(posedge clk_conv_i) begin
		cc <= cc + 1;
		sco_q <= sco;
		if (sco && !sco_q) begin
			rise_b <= rise_a;
			rise_a <= cc;
		end
		if (!sco && sco_q) begin
			fall_a <= cc;
		end
	end
	dlei_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
		.data_clock_polarity_i(pol), .interpolation_select_i(sel), .clk_conv_i(clk_conv_i),
		.sample_data_i(sample_data), .sample_ready_o(sample_ready), .sample_clock_out_o(sco),
		.dac_ready_i(dac_ready), .dac_valid_o(dac_valid), .dac_data_o(dac_data));
	dlei_engine eng (.clk_conv_i(clk_conv_i), .rst_n_i(rst_n_i), .sample_clock_out_i(sco),
		.data_clock_polarity_i(pol), .value_i(eng_val), .sample_data_o(sample_data));

	// ==========================================================
	// Helpers
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [23:0] ph(input int v, input int p);
		return 24'(((v % p) + p) % p);
	endfunction
	task automatic chk_reg(input string what, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic chk_link(input string what, input logic [23:0] e, input logic [23:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys_i);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys_i);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic setcfg(input logic [3:0] code, input logic p, input logic [1:0] s);
		logic [7:0] rd;
		lfsr = lfsr_next(lfsr);
		reg_write(dlei_pkg::LATCH_EDGE_ADDR, {code, lfsr[3:0]});
		reg_read(dlei_pkg::LATCH_EDGE_ADDR, rd);
		chk_reg("latch_edge_adjust_reg", {code, lfsr[3:0]}, rd);
		@(posedge clk_sys_i);
		pol <= p;
		sel <= s;
		eng_val <= lfsr[15:4];
		repeat (100) @(posedge clk_conv_i);
		chk_link("dac_data", {lfsr[15:4], lfsr[15:4]}, dac_data);
		chk_link("dac_valid", 24'h000001, {23'h000000, dac_valid});
	endtask
	task automatic complete_run();
		if (fails == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		int f, p, sh, base, code, dlt;
		logic [7:0] rd;
		rst_n_i <= 1'b0;
		fork
			begin
				#600000;
				fails++;
				complete_run();
			end
		join_none
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (8) @(posedge clk_conv_i);
		reg_read(dlei_pkg::LATCH_EDGE_ADDR, rd);
		chk_reg("reset_value", dlei_pkg::LATCH_EDGE_RESET, rd);
		reg_write(8'h06, 8'hFF);
		reg_read(8'h06, rd);
		chk_reg("unmapped_read", dlei_pkg::RDATA_IDLE, rd);
		reg_read(dlei_pkg::LATCH_EDGE_ADDR, rd);
		chk_reg("unmapped_write", dlei_pkg::LATCH_EDGE_RESET, rd);
		for (int s = 3; s >= 0; s--) begin
			f = 1 << s;
			p = (f == 1) ? 2 : f;
			sh = 3 - s;
			setcfg(4'h0, 1'b0, 2'(s));
			base = rise_a;
			chk_link("data_clock_period", 24'(p), 24'(rise_a - rise_b));
			setcfg(4'h0, 1'b1, 2'(s));
			chk_link("fall_phase_pol1", ph(base + p / 2, p), ph(fall_a, p));
			for (int k = 0; k < 3; k++) begin
				code = (k == 0) ? (1 << sh) : (k == 1) ? (16 - (1 << sh)) : int'(lfsr[15:12]);
				code = code & ~((1 << sh) - 1) & 15;
				dlt = (s == 0) ? 0 : ($signed(4'(code)) >>> sh);
				setcfg(4'(code), 1'b0, 2'(s));
				chk_link("rise_phase", ph(base + dlt, p), ph(rise_a, p));
			end
		end
		@(posedge clk_conv_i);
		dac_ready <= 1'b0;
		repeat (40) @(posedge clk_conv_i);
		chk_link("sample_ready_full", 24'h000000, {23'h000000, sample_ready});
		dac_ready <= 1'b1;
		repeat (40) @(posedge clk_conv_i);
		chk_link("sample_ready_drained", 24'h000001, {23'h000000, sample_ready});
		setcfg(4'h0, 1'b0, 2'b00);
		complete_run();
	end
endmodule
